// ### src/tlih_pkg.sv
// Package: constants and types shared by the two-level interrupt handler
package tlih_pkg;
	localparam int TLIH_NUM_SRC = 18;
	localparam int TLIH_IDX_W = 5;
	localparam int TLIH_ADDR_W = 8;
	// Register byte offsets
	localparam logic [TLIH_ADDR_W-1:0] TLIH_OFF_ENABLE = 8'h00;
	localparam logic [TLIH_ADDR_W-1:0] TLIH_OFF_LEVEL = 8'h04;
	localparam logic [TLIH_ADDR_W-1:0] TLIH_OFF_PEND = 8'h08;
	localparam logic [TLIH_ADDR_W-1:0] TLIH_OFF_PCLR = 8'h0C;
	localparam logic [TLIH_ADDR_W-1:0] TLIH_OFF_STAT = 8'h10;
	localparam logic [TLIH_ADDR_W-1:0] TLIH_OFF_AUTOCLR = 8'h14;
	localparam int TLIH_GIE_BIT = 31;
	localparam logic [31:0] TLIH_RST_ENABLE = 32'h0000_0000;
	localparam logic [31:0] TLIH_RST_LEVEL = 32'h0000_0000;
	localparam logic [31:0] TLIH_RST_AUTOCLR = 32'h0000_000F;
	// Vector map
	localparam logic [15:0] TLIH_VEC_BASE = 16'h0003;
	localparam logic [15:0] TLIH_VEC_STEP = 16'h0008;
	// Status fields
	localparam int TLIH_ST_INSVC_LO = 0;
	localparam int TLIH_ST_INSVC_HI = 1;
	localparam int TLIH_ST_STATE_LSB = 4;
	localparam int TLIH_ST_SRC_LSB = 8;
	typedef enum logic [1:0] {
		TLIH_IDLE = 2'b00,
		TLIH_CALL = 2'b01,
		TLIH_HOLD = 2'b10
	} tlih_state_t;
endpackage

// ### src/tlih_req_if.sv
// Interface: request vector from the masking stage to the arbiter
`timescale 1ns/10ps
interface tlih_req_if #(parameter int N = 18);
	logic [N-1:0] req;
	logic [N-1:0] lvl;
	logic any_hi;
	logic any_lo;
	logic [4:0] hi_idx;
	logic [4:0] lo_idx;
	modport mask_mp (output req, output lvl);
	modport arb_mp (input req, input lvl, output any_hi, output any_lo, output hi_idx, output lo_idx);
	modport use_mp (input any_hi, input any_lo, input hi_idx, input lo_idx);
endinterface

// ### src/tlih_mask.sv
// Per-source request forming: pending AND enable AND global enable
`timescale 1ns/10ps
module tlih_mask import tlih_pkg::*; #(
	parameter int N = TLIH_NUM_SRC
) (
	input wire logic [N-1:0] i_pend,
	input wire logic [N-1:0] i_en,
	input wire logic [N-1:0] i_level,
	input wire logic i_gie,
	tlih_req_if.mask_mp rq
);
	genvar g;
	generate
		for (g = 0; g < N; g++) begin : g_src
			assign rq.req[g] = i_pend[g] & i_en[g] & i_gie;
			assign rq.lvl[g] = i_level[g];
		end
	endgenerate
endmodule

// ### src/tlih_arb.sv
// Fixed-order arbiter per level: lowest index wins
`timescale 1ns/10ps
module tlih_arb import tlih_pkg::*; #(
	parameter int N = TLIH_NUM_SRC
) (
	tlih_req_if.arb_mp rq
);
	function automatic logic [4:0] first_set(input logic [N-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int k = N - 1; k >= 0; k--) begin
			if (v[k]) begin
				r = 5'(k);
			end
		end
		return r;
	endfunction

	always_comb begin
		rq.any_hi = |(rq.req & rq.lvl);
		rq.any_lo = |(rq.req & ~rq.lvl);
		rq.hi_idx = first_set(rq.req & rq.lvl);
		rq.lo_idx = first_set(rq.req & ~rq.lvl);
	end
endmodule

// ### src/tlih_top.sv
// Two-level interrupt handler: flags, masking, priority and vector call control
//
// Design decisions made here: the APB slave port and the register offsets.
`timescale 1ns/10ps
module tlih_top import tlih_pkg::*; #(
	parameter int N = TLIH_NUM_SRC
) (
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic [N-1:0] i_src_event,
	input wire logic i_insn_done,
	input wire logic i_call_ack,
	input wire logic i_irq_return,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [TLIH_ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	output logic o_call_req,
	output logic [15:0] o_vector
);
	// ------------------------------------------------------------
	// Register file and pending flags
	// ------------------------------------------------------------
	logic [N-1:0] pend_ff, nxt_pend;
	logic [N-1:0] en_ff, nxt_en;
	logic gie_ff, nxt_gie;
	logic [N-1:0] lvl_ff, nxt_lvl;
	logic [N-1:0] aclr_ff, nxt_aclr;
	logic [31:0] prdata_ff, nxt_prdata;
	logic pready_ff, nxt_pready;
	logic pslverr_ff, nxt_pslverr;
	logic [N-1:0] set_vec, clr_vec;

	// Arbitration / sequencing state
	tlih_state_t state_ff, nxt_state;
	logic insvc_lo_ff, nxt_insvc_lo;
	logic insvc_hi_ff, nxt_insvc_hi;
	logic [1:0] lvl_stack_ff, nxt_lvl_stack;
	logic hold_ff, nxt_hold;
	logic call_ff, nxt_call;
	logic [15:0] vec_ff, nxt_vec;
	logic [4:0] src_ff, nxt_src;

	tlih_req_if #(.N(N)) rq ();

	tlih_mask #(.N(N)) u_mask (
		.i_pend(pend_ff),
		.i_en(en_ff),
		.i_level(lvl_ff),
		.i_gie(gie_ff),
		.rq(rq.mask_mp)
	);

	tlih_arb #(.N(N)) u_arb (
		.rq(rq.arb_mp)
	);

	function automatic logic [N-1:0] onehot(input logic [4:0] idx);
		logic [N-1:0] r;
		r = '0;
		r[idx] = 1'b1;
		return r;
	endfunction

	// Writes commit only at the edge where pready is seen high
	wire logic wr_acc = i_psel & i_penable & i_pwrite & pready_ff;
	wire logic rd_setup = i_psel & ~i_penable & ~i_pwrite;
	wire logic take_call = (state_ff == TLIH_CALL) & i_call_ack;

	always_comb begin
		set_vec = i_src_event;
		clr_vec = '0;
		nxt_en = en_ff;
		nxt_gie = gie_ff;
		nxt_lvl = lvl_ff;
		nxt_aclr = aclr_ff;
		nxt_prdata = prdata_ff;
		nxt_pready = 1'b0;
		nxt_pslverr = 1'b0;
		if (wr_acc) begin
			case (i_paddr)
				TLIH_OFF_ENABLE: begin
					nxt_en = i_pwdata[N-1:0];
					nxt_gie = i_pwdata[TLIH_GIE_BIT];
				end
				TLIH_OFF_LEVEL: nxt_lvl = i_pwdata[N-1:0];
				TLIH_OFF_PEND: set_vec = i_src_event | i_pwdata[N-1:0];
				TLIH_OFF_PCLR: clr_vec = i_pwdata[N-1:0];
				TLIH_OFF_AUTOCLR: nxt_aclr = i_pwdata[N-1:0];
				default: ;
			endcase
		end
		// Hardware clear on vectoring
		if (take_call & aclr_ff[src_ff]) begin
			clr_vec = clr_vec | onehot(src_ff);
		end
		// Any set in the same cycle beats a clear, so no event is lost
		nxt_pend = (pend_ff & ~clr_vec) | set_vec;
		if (rd_setup) begin
			case (i_paddr)
				TLIH_OFF_ENABLE: nxt_prdata = 32'({gie_ff, 31'(en_ff)});
				TLIH_OFF_LEVEL: nxt_prdata = 32'(lvl_ff);
				TLIH_OFF_PEND: nxt_prdata = 32'(pend_ff);
				TLIH_OFF_PCLR: nxt_prdata = 32'h0000_0000;
				TLIH_OFF_AUTOCLR: nxt_prdata = 32'(aclr_ff);
				TLIH_OFF_STAT: begin
					nxt_prdata = 32'h0000_0000;
					nxt_prdata[TLIH_ST_INSVC_LO] = lvl_stack_ff[0];
					nxt_prdata[TLIH_ST_INSVC_HI] = lvl_stack_ff[1];
					nxt_prdata[TLIH_ST_STATE_LSB +: 2] = state_ff;
					nxt_prdata[TLIH_ST_SRC_LSB +: 5] = src_ff;
				end
				default: nxt_prdata = 32'h0000_0000;
			endcase
		end
		// Error status decided on the first access edge, shown with pready
		if (i_psel & i_penable & ~pready_ff) begin
			nxt_pready = 1'b1;
			case (i_paddr)
				TLIH_OFF_ENABLE, TLIH_OFF_LEVEL, TLIH_OFF_PEND,
				TLIH_OFF_PCLR, TLIH_OFF_AUTOCLR, TLIH_OFF_STAT: nxt_pslverr = 1'b0;
				default: nxt_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			pend_ff <= '0;
			en_ff <= N'(TLIH_RST_ENABLE);
			gie_ff <= 1'b0;
			lvl_ff <= N'(TLIH_RST_LEVEL);
			aclr_ff <= N'(TLIH_RST_AUTOCLR);
			prdata_ff <= 32'h0000_0000;
			pready_ff <= 1'b0;
			pslverr_ff <= 1'b0;
		end else begin
			pend_ff <= nxt_pend;
			en_ff <= nxt_en;
			gie_ff <= nxt_gie;
			lvl_ff <= nxt_lvl;
			aclr_ff <= nxt_aclr;
			prdata_ff <= nxt_prdata;
			pready_ff <= nxt_pready;
			pslverr_ff <= nxt_pslverr;
		end
	end

	// ------------------------------------------------------------
	// Priority resolution and call sequencing
	// ------------------------------------------------------------
	// Decoded every cycle; a request only wins over strictly lower service
	logic win_hi, win_lo;
	always_comb begin
		win_hi = rq.any_hi & ~insvc_hi_ff;
		win_lo = rq.any_lo & ~insvc_hi_ff & ~insvc_lo_ff;
	end

	always_comb begin
		nxt_state = state_ff;
		nxt_insvc_lo = insvc_lo_ff;
		nxt_insvc_hi = insvc_hi_ff;
		nxt_lvl_stack = lvl_stack_ff;
		nxt_hold = hold_ff;
		nxt_call = call_ff;
		nxt_vec = vec_ff;
		nxt_src = src_ff;
		case (state_ff)
			TLIH_IDLE, TLIH_HOLD: begin
				// Return closes the innermost level; next call waits one instruction
				if (i_irq_return) begin
					if (insvc_hi_ff) begin
						nxt_insvc_hi = 1'b0;
					end else begin
						nxt_insvc_lo = 1'b0;
					end
					nxt_state = TLIH_HOLD;
				end else if (i_insn_done & (win_hi | win_lo)) begin
					nxt_src = win_hi ? rq.hi_idx : rq.lo_idx;
					nxt_hold = win_hi;
					nxt_vec = TLIH_VEC_BASE + 16'(nxt_src) * TLIH_VEC_STEP;
					nxt_call = 1'b1;
					nxt_state = TLIH_CALL;
				end else if (i_insn_done) begin
					nxt_state = TLIH_IDLE;
				end
			end
			TLIH_CALL: begin
				if (i_call_ack) begin
					nxt_call = 1'b0;
					if (hold_ff) begin
						nxt_insvc_hi = 1'b1;
					end else begin
						nxt_insvc_lo = 1'b1;
					end
					nxt_state = TLIH_IDLE;
				end
			end
			default: nxt_state = TLIH_IDLE;
		endcase
		nxt_lvl_stack = {nxt_insvc_hi, nxt_insvc_lo};
	end

	always_ff @(posedge i_sys_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			state_ff <= TLIH_IDLE;
			insvc_lo_ff <= 1'b0;
			insvc_hi_ff <= 1'b0;
			lvl_stack_ff <= 2'h0;
			hold_ff <= 1'b0;
			call_ff <= 1'b0;
			vec_ff <= 16'h0000;
			src_ff <= 5'h00;
		end else begin
			state_ff <= nxt_state;
			insvc_lo_ff <= nxt_insvc_lo;
			insvc_hi_ff <= nxt_insvc_hi;
			lvl_stack_ff <= nxt_lvl_stack;
			hold_ff <= nxt_hold;
			call_ff <= nxt_call;
			vec_ff <= nxt_vec;
			src_ff <= nxt_src;
		end
	end

	assign o_prdata = prdata_ff;
	assign o_pready = pready_ff;
	assign o_pslverr = pslverr_ff;
	assign o_call_req = call_ff;
	assign o_vector = vec_ff;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	property p_gie_blocks;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		(state_ff != TLIH_CALL && !gie_ff) |=> !call_ff;
	endproperty
	a_gie_blocks: assert property (p_gie_blocks) else $error("call without global enable");

	property p_event_sets;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		i_src_event[0] |=> pend_ff[0];
	endproperty
	a_event_sets: assert property (p_event_sets) else $error("event lost");

	property p_vec_map;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		call_ff |-> o_vector == TLIH_VEC_BASE + 16'(src_ff) * TLIH_VEC_STEP;
	endproperty
	a_vec_map: assert property (p_vec_map) else $error("wrong vector");

	property p_hi_no_preempt;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		insvc_hi_ff && state_ff != TLIH_CALL && !i_irq_return |=> !$rose(call_ff);
	endproperty
	a_hi_no_preempt: assert property (p_hi_no_preempt) else $error("high preempted");

	property p_ret_hold;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		(state_ff != TLIH_CALL && i_irq_return) |=> state_ff == TLIH_HOLD ##0 !call_ff;
	endproperty
	a_ret_hold: assert property (p_ret_hold) else $error("no wait after return");

	property p_one_insn;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		(state_ff == TLIH_HOLD && i_insn_done && !i_irq_return && (|rq.req)
			&& !insvc_hi_ff && !insvc_lo_ff) |=> call_ff;
	endproperty
	a_one_insn: assert property (p_one_insn) else $error("re-entry late");

	property p_call_enabled;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(call_ff) |-> (|($past(en_ff) & onehot(src_ff))) && $past(gie_ff);
	endproperty
	a_call_enabled: assert property (p_call_enabled) else $error("disabled source called");

	property p_hi_first;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(call_ff) && $past(rq.any_hi) && !$past(insvc_hi_ff) |-> hold_ff;
	endproperty
	a_hi_first: assert property (p_hi_first) else $error("low beat high");

	property p_insn_wait;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(call_ff) |-> $past(i_insn_done);
	endproperty
	a_insn_wait: assert property (p_insn_wait) else $error("call before instruction end");

	property p_insvc_set;
		@(posedge i_sys_clk) disable iff (!i_resetn)
		take_call && !hold_ff |=> insvc_lo_ff;
	endproperty
	a_insvc_set: assert property (p_insvc_set) else $error("in-service not set");

	c_call_lo: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
		take_call && !hold_ff);
	c_preempt: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
		take_call && hold_ff && insvc_lo_ff);
	c_reentry: cover property (@(posedge i_sys_clk) disable iff (!i_resetn)
		state_ff == TLIH_HOLD ##1 $rose(call_ff));
endmodule

// ### dv/tlih_core_model.sv
// Core-side partner: instruction boundaries and vector call acknowledge
`timescale 1ns/10ps
module tlih_core_model (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_call_req,
	input wire logic i_slow,
	output logic o_insn_done,
	output logic o_call_ack
);
	int wait_n;
	always @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			o_insn_done <= 1'b0;
			o_call_ack <= 1'b0;
			wait_n <= 0;
		end else begin
			// Boundary every other cycle, like a two-cycle instruction
			o_insn_done <= ~o_insn_done;
			o_call_ack <= 1'b0;
			// Slow core delays the call; ack once per request
			if (i_call_req && !o_call_ack) begin
				if (wait_n >= (i_slow ? 3 : 0)) begin
					o_call_ack <= 1'b1;
					wait_n <= 0;
				end else begin
					wait_n <= wait_n + 1;
				end
			end
		end
	end
endmodule

// ### dv/tb_tlih_top.sv
// Self-checking bench for the two-level interrupt handler
`timescale 1ns/10ps
module tb_tlih_top import tlih_pkg::*;;
	logic clk, rstn, done, ack, ret, psel, pen, pwr, slow;
	logic [17:0] evt;
	logic [7:0] paddr;
	logic [31:0] pwd, prd, r;
	logic prdy, perr, creq, e;
	logic [15:0] vec;
	logic [17:0] p, l;
	int fails, checks, cyc, seed, k;
	tlih_top u_dut (.i_sys_clk(clk), .i_resetn(rstn), .i_src_event(evt), .i_insn_done(done),
		.i_call_ack(ack), .i_irq_return(ret), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
		.i_paddr(paddr), .i_pwdata(pwd), .o_prdata(prd), .o_pready(prdy), .o_pslverr(perr),
		.o_call_req(creq), .o_vector(vec));
	tlih_core_model u_core (.i_clk(clk), .i_resetn(rstn), .i_call_req(creq), .i_slow(slow),
		.o_insn_done(done), .o_call_ack(ack));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	// ----------------------------------------
	// Shared tasks and reference model
	// ----------------------------------------
	task automatic close_out;
		if (fails == 0 && checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			close_out;
		end
	end
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, x, s);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Only the bench timeout ends a hung wait
		do begin
			@(posedge clk);
		end while (prdy !== 1'b1);
		r = prd;
		e = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk("read", r, x);
	endtask
	task automatic pulse_ret;
		ret <= 1'b1;
		@(posedge clk);
		ret <= 1'b0;
		// Let the low level be seen before any next pulse
		@(posedge clk);
	endtask
	task automatic take_call(input int s);
		int n;
		n = 0;
		while (creq !== 1'b1 && n < 40) begin
			@(posedge clk);
			n++;
		end
		chk("call_req", {31'h0, creq}, 32'h1);
		chk("vector", {16'h0000, vec}, 32'(TLIH_VEC_BASE + TLIH_VEC_STEP * 16'(s)));
		while (creq === 1'b1 && n < 80) begin
			@(posedge clk);
			n++;
		end
	endtask
	task automatic no_call;
		repeat (12) begin
			@(posedge clk);
			chk("call_req", {31'h0, creq}, 32'h0);
		end
	endtask
	// Winner: high level first, then lowest index within a level
	function automatic int win(input logic [17:0] pp, input logic [17:0] ll);
		for (int j = 0; j < 18; j++) if (pp[j] && ll[j]) return j;
		for (int j = 0; j < 18; j++) if (pp[j]) return j;
		return -1;
	endfunction
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{rstn, evt, ret, psel, pen, pwr, paddr, pwd, slow} = '0;
		fails = 0;
		checks = 0;
		cyc = 0;
		seed = 32'h271C;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		rd(TLIH_OFF_ENABLE, TLIH_RST_ENABLE);
		rd(TLIH_OFF_LEVEL, TLIH_RST_LEVEL);
		rd(TLIH_OFF_AUTOCLR, TLIH_RST_AUTOCLR);
		rd(8'h18, 32'h0);
		chk("slverr", {31'h0, e}, 32'h1);
		evt <= 18'h00020;
		@(posedge clk);
		evt <= 18'h0;
		rd(TLIH_OFF_PEND, 32'h20);
		apb(1'b1, TLIH_OFF_ENABLE, 32'h20);
		no_call;
		apb(1'b1, TLIH_OFF_ENABLE, 32'h8000_0020);
		take_call(5);
		apb(1'b0, TLIH_OFF_STAT, 32'h0);
		chk("in_service", r & 32'h3, 32'h1);
		rd(TLIH_OFF_PEND, 32'h20);
		pulse_ret;
		take_call(5);
		apb(1'b1, TLIH_OFF_PCLR, 32'h20);
		pulse_ret;
		no_call;
		slow <= 1'b1;
		apb(1'b1, TLIH_OFF_LEVEL, 32'h82);
		apb(1'b1, TLIH_OFF_PEND, 32'h40);
		apb(1'b1, TLIH_OFF_ENABLE, 32'h8000_00C2);
		take_call(6);
		apb(1'b1, TLIH_OFF_PEND, 32'h80);
		take_call(7);
		apb(1'b0, TLIH_OFF_STAT, 32'h0);
		chk("in_service", r & 32'h3, 32'h3);
		apb(1'b1, TLIH_OFF_PEND, 32'h2);
		no_call;
		apb(1'b1, TLIH_OFF_PCLR, 32'hC0);
		pulse_ret;
		take_call(1);
		rd(TLIH_OFF_PEND, 32'h0);
		apb(1'b1, TLIH_OFF_ENABLE, 32'h0);
		pulse_ret;
		pulse_ret;
		for (int i = 0; i < 6; i++) begin
			p = 18'($random(seed)) | (18'h1 << (i * 3));
			l = 18'($random(seed));
			slow <= $random(seed);
			apb(1'b1, TLIH_OFF_PCLR, 32'h3FFFF);
			apb(1'b1, TLIH_OFF_LEVEL, {14'h0, l});
			apb(1'b1, TLIH_OFF_PEND, {14'h0, p});
			apb(1'b1, TLIH_OFF_ENABLE, 32'h8003_FFFF);
			k = win(p, l);
			take_call(k);
			if (TLIH_RST_AUTOCLR[k]) p[k] = 1'b0;
			apb(1'b1, TLIH_OFF_ENABLE, 32'h0);
			rd(TLIH_OFF_PEND, {14'h0, p});
			pulse_ret;
		end
		// Give the post-return wait time to end before looking at status
		repeat (2) @(posedge clk);
		apb(1'b0, TLIH_OFF_STAT, 32'h0);
		chk("status", r, 32'(k) << TLIH_ST_SRC_LSB);
		close_out;
	end
endmodule
